/* bench/core_fault_detect_exception_tb_top.sv */
// self-checking bench for the fault detection and exception selection block
`timescale 1ns/100ps
`include "fault_detect_defines.svh"

module core_fault_detect_exception_tb_top;
  logic clk, rst_b, regWr, regRd, instValid, decodeIllegal, fetchErr, flowChange;
  logic opReadErr, opWriteErr, writesPending, ctrlXfer, ctrlTargetBit0, reqAck;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData;
  logic [15:0] opword, ext1;
  logic [1:0]  extCount, sspLow;
  logic reqValid, reqReset, reqResetOpcode, reqRollback, reqRetOverwrite, nopStall;
  logic [7:0]  reqVector;
  logic [3:0]  reqFs, reqFormat;
  int err_count = 0, compares = 0, cycles = 0;
  logic [2:0]  seenFlags;  // {reqResetOpcode, reqRollback, reqRetOverwrite} while the request stands
  // one-hot selects for pulse, order {ctrlXfer, opWriteErr, opReadErr, flowChange, fetchErr}
  localparam logic [4:0] EV_FETCH = 5'h01, EV_FLUSH = 5'h02, EV_READ = 5'h04, EV_WRITE = 5'h08, EV_XFER = 5'h10;

  core_fault_detect_exception i_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .instValid(instValid), .opword(opword), .ext1(ext1),
    .extCount(extCount), .decodeIllegal(decodeIllegal), .fetchErr(fetchErr), .flowChange(flowChange),
    .opReadErr(opReadErr), .opWriteErr(opWriteErr), .writesPending(writesPending), .ctrlXfer(ctrlXfer),
    .ctrlTargetBit0(ctrlTargetBit0), .sspLow(sspLow), .reqAck(reqAck), .reqValid(reqValid),
    .reqVector(reqVector), .reqFs(reqFs), .reqFormat(reqFormat), .reqReset(reqReset),
    .reqResetOpcode(reqResetOpcode), .reqRollback(reqRollback), .reqRetOverwrite(reqRetOverwrite),
    .nopStall(nopStall));
  seq_ack_model i_seq (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqAck(reqAck));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang anywhere ends the run here; the whole sequence takes well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a; regWrData <= d; regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  task automatic issue(input logic [15:0] op, input logic [15:0] e1, input logic [1:0] n, input logic ill);
    @(posedge clk);
    instValid <= 1'b1; opword <= op; ext1 <= e1; extCount <= n; decodeIllegal <= ill;
    @(posedge clk);
    instValid <= 1'b0; decodeIllegal <= 1'b0;
  endtask
  // fields are compared while the request stands, then the ack must clear it
  task automatic expreq(input logic [7:0] vec, input logic [3:0] fs, input logic rs, input logic [3:0] fmt);
    int i;
    i = 0;
    #1;
    while (reqValid !== 1'b1 && i < 20) begin
      @(posedge clk) #1 i++;
    end
    // rollback and return-overwrite flags are cleared by the acknowledge, so the flags are caught here
    seenFlags = {reqResetOpcode, reqRollback, reqRetOverwrite};
    chk({reqValid, reqVector, reqFs, reqReset, reqFormat}, {1'b1, vec, fs, rs, fmt});
    repeat (6) @(posedge clk);
    #1 chk(reqValid, 1'b0);
  endtask
  task automatic noreq();
    repeat (6) @(posedge clk);
    #1 chk(reqValid, 1'b0);
  endtask
  task automatic pulse(input logic [4:0] sel);
    @(posedge clk) {ctrlXfer, opWriteErr, opReadErr, flowChange, fetchErr} <= sel;
    @(posedge clk) {ctrlXfer, opWriteErr, opReadErr, flowChange, fetchErr} <= 5'h00;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(4'h0, 32'h0); rd(4'hc, 32'h0); wr(4'hc, 32'hf); rd(4'hc, 32'h0);
    wr(4'h4, 32'h7); rd(4'h4, 32'h7); wr(4'h4, 32'h0);
  endtask
  task automatic t_illegal();
    issue(`OPW_ILLEGAL, 16'h0, 2'h0, 1'b0); expreq(8'h04, 4'h0, 1'b0, 4'h4);
    issue(16'h4e7b, 16'h0, 2'h0, 1'b1); expreq(8'h04, 4'h0, 1'b1, 4'h4);
    chk(seenFlags[2], 1'b1);
    @(posedge clk) sspLow <= 2'h3;
    issue(16'ha000, 16'h0, 2'h0, 1'b0); expreq(8'h0a, 4'h0, 1'b1, 4'h7);
    wr(4'h0, 32'h2);
    issue(16'hf000, 16'h0, 2'h0, 1'b0); expreq(8'h0b, 4'h0, 1'b0, 4'h7);
    issue(`OPW_ILLEGAL, 16'h0, 2'h0, 1'b0); expreq(8'h04, 4'h0, 1'b0, 4'h7);
    @(posedge clk) sspLow <= 2'h0;
    issue(`OPW_STOP, 16'h2000, 2'h1, 1'b0); expreq(8'h04, 4'h0, 1'b0, 4'h4);
    wr(4'h0, 32'h0);
    issue(`OPW_HALT, 16'h0, 2'h0, 1'b0); expreq(8'h04, 4'h0, 1'b1, 4'h4);
    wr(4'h4, 32'h7);
    issue(`OPW_HALT, 16'h0, 2'h0, 1'b0); noreq();
    issue(`OPW_STOP, 16'h2000, 2'h1, 1'b0); noreq();
    issue(16'h2000, `OPW_ILLEGAL, 2'h2, 1'b0); noreq();
  endtask
  task automatic t_access();
    pulse(EV_FETCH); pulse(EV_FLUSH);
    issue(16'h2000, 16'h0, 2'h0, 1'b0); noreq();
    pulse(EV_FETCH);
    issue(16'h2000, 16'h0, 2'h0, 1'b0); expreq(8'h02, 4'h4, 1'b1, 4'h4);
    chk(seenFlags[1], 1'b1);
    pulse(EV_READ); expreq(8'h02, 4'hc, 1'b1, 4'h4);
    chk(seenFlags[2:1], 2'b00);
    wr(4'h0, 32'h1);
    writesPending <= 1'b1; pulse(EV_WRITE);
    issue(`OPW_NOP, 16'h0, 2'h0, 1'b0);
    #1 chk({nopStall, reqValid}, 2'b10);
    @(posedge clk) writesPending <= 1'b0;
    expreq(8'h02, 4'h8, 1'b0, 4'h4);
  endtask
  task automatic t_address();
    issue(16'h2030, 16'h0900, 2'h1, 1'b0); expreq(8'h03, 4'h0, 1'b0, 4'h4);
    issue(16'h2030, 16'h0e00, 2'h1, 1'b0); expreq(8'h03, 4'h0, 1'b0, 4'h4);
    wr(4'h0, 32'h0);
    issue(16'h2030, 16'h0000, 2'h1, 1'b0); expreq(8'h03, 4'h0, 1'b1, 4'h4);
    issue(16'h2030, 16'h0800, 2'h1, 1'b0); noreq();
    @(posedge clk) ctrlTargetBit0 <= 1'b1;
    pulse(EV_XFER); expreq(8'h03, 4'h0, 1'b1, 4'h4);
    chk(seenFlags[0], 1'b0);
    issue(`OPW_RTS, 16'h0, 2'h0, 1'b0); pulse(EV_XFER); expreq(8'h03, 4'h0, 1'b1, 4'h4);
    chk(seenFlags[0], 1'b1);
    @(posedge clk) ctrlTargetBit0 <= 1'b0;
    pulse(EV_XFER); noreq();
  endtask

  initial begin
    {regWr, regRd, instValid, decodeIllegal, fetchErr, flowChange, opReadErr, opWriteErr} = 8'h00;
    {writesPending, ctrlXfer, ctrlTargetBit0} = 3'h0;
    regAddr = 4'h0; regWrData = 32'h0; opword = 16'h0; ext1 = 16'h0; extCount = 2'h0; sspLow = 2'h0;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_illegal();
    t_access();
    t_address();
    results();
  end
endmodule // core_fault_detect_exception_tb_top

/* bench/seq_ack_model.sv */
// core sequencer model that takes fault requests after a settable wait
`timescale 1ns/100ps

module seq_ack_model #(
  parameter int ACK_WAIT = 2
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic reqValid,
  output logic      reqAck
);
  logic [3:0] waitCnt;
  logic [3:0] next_waitCnt;
  logic       next_reqAck;

  // ack pulses once per request; a held ack would swallow the next one
  always_comb begin
    next_waitCnt = (reqValid && !reqAck) ? waitCnt + 4'h1 : 4'h0;
    next_reqAck  = reqValid && !reqAck && (waitCnt == 4'(ACK_WAIT));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt <= 4'h0;
      reqAck  <= 1'b0;
    end else begin
      waitCnt <= next_waitCnt;
      reqAck  <= next_reqAck;
    end
  end
endmodule // seq_ack_model

/* pkg/fault_detect_defines.svh */
// constants for the fault detection and exception selection block
//
// Behaviour
// - access error raises illegal-address reset unless addr_reset_disable, then exception
// - fetch faults held until the word executes; flushed prefetch faults never report
// - instruction with faulted fetch words aborts with no register change
// - operand read error aborts at once; auto address updates are kept
// - multi_reg_move load keeps registers written before a read fault
// - operand write errors report imprecisely after the writing instruction completes
// - no_operation_sync stalls until writes drain and reports any pending write error
// - address error raises reset unless addr_reset_disable is 1, then exception
// - control transfer to a target with bit 0 set is an address error
// - word index, scale of eight or full-format index is an address error
// - address error on subroutine return overwrites the stacked return pc
// - illegal instruction raises opcode reset unless opcode_reset_disable, then exception
// - opword 0x4afc always gives an illegal-instruction exception, never reset
// - instructions are 16, 32 or 48 bits: opword plus up to two extensions
// - opword splits into 4-bit line, 6-bit opmode and 6-bit effective address
// - illegal opcodes take vector 4, line-a vector 10, line-f vector 11
// - only the opword is checked for illegal codes, never extension words
// - stop with neither low-power stop nor wait enabled is illegal
// - halt with bkgnd_debug_enable at 0 is illegal
// - stop and halt illegal cases obey opcode_reset_disable like others
// - fault status 0100 fetch, 1000 write, 1100 read, zero otherwise
// - frame format is 4 to 7 from low two bits of the stack pointer
`ifndef FAULT_DETECT_DEFINES_SVH
`define FAULT_DETECT_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define OFS_CORE_CONFIG   4'h0
`define OFS_MODE_CTRL     4'h4
`define OFS_FAULT_STATUS  4'h8
`define BIT_ADDR_RST_DIS  0
`define BIT_OPC_RST_DIS   1
`define BIT_STOP_EN       0
`define BIT_WAIT_EN       1
`define BIT_BKGND_EN      2
`define CORE_CONFIG_RST   2'h0
`define MODE_CTRL_RST     3'h0

// ----------------------------------------------------------------
// vectors, fault status codes, frame format base
// ----------------------------------------------------------------
`define VEC_ACCESS        8'h02
`define VEC_ADDRESS       8'h03
`define VEC_ILLEGAL       8'h04
`define VEC_LINE_A        8'h0a
`define VEC_LINE_F        8'h0b
`define FS_NONE           4'h0
`define FS_FETCH          4'h4
`define FS_WRITE          4'h8
`define FS_READ           4'hc
`define FORMAT_BASE       2'h1

// ----------------------------------------------------------------
// opwords and decode fields
// ----------------------------------------------------------------
`define OPW_ILLEGAL       16'h4afc
`define OPW_NOP           16'h4e71
`define OPW_STOP          16'h4e72
`define OPW_RTS           16'h4e75
`define OPW_HALT          16'h4ac8
`define OPW_FIXED_HI      12'h4e7
`define LINE_MISC         4'h4
`define LINE_A            4'ha
`define LINE_F            4'hf
`define MOV3Q_OPMODE_LO   3'h5
`define WDEBUG_HI         4'hb
`define EA_MODE_INDEX     3'h6
`define EA_MODE_SPECIAL   3'h7
`define EA_REG_PC_INDEX   3'h3
`define EXT_SIZE_BIT      11
`define EXT_SCALE_HI      10
`define EXT_SCALE_LO      9
`define EXT_FULL_BIT      8
`define SCALE_EIGHT       2'h3

`endif

/* pkg/fault_detect_pkg.sv */
// types for the fault detection and exception selection block
package fault_detect_pkg;

  // sequencer handshake state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_NOPWAIT = 3'b010,
    ST_REQ     = 3'b100
  } seq_state_t;

endpackage

/* rtl/core_fault_detect_exception.sv */
// fault detection and reset-or-exception selection for the execute pipeline
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "fault_detect_defines.svh"

module core_fault_detect_exception (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // execute pipeline
  input  wire logic        instValid,
  input  wire logic [15:0] opword,
  input  wire logic [15:0] ext1,
  input  wire logic [1:0]  extCount,
  input  wire logic        decodeIllegal,
  input  wire logic        fetchErr,
  input  wire logic        flowChange,
  input  wire logic        opReadErr,
  input  wire logic        opWriteErr,
  input  wire logic        writesPending,
  input  wire logic        ctrlXfer,
  input  wire logic        ctrlTargetBit0,
  input  wire logic [1:0]  sspLow,
  input  wire logic        reqAck,
  // request to the core sequencer
  output logic             reqValid,
  output logic [7:0]       reqVector,
  output logic [3:0]       reqFs,
  output logic [3:0]       reqFormat,
  output logic             reqReset,
  output logic             reqResetOpcode,
  output logic             reqRollback,
  output logic             reqRetOverwrite,
  output logic             nopStall
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fault_detect_pkg::seq_state_t state, next_state;
  logic [1:0]  coreConfig, next_coreConfig;
  logic [2:0]  modeCtrl, next_modeCtrl;
  logic        pendFetchErr, next_pendFetchErr;
  logic        pendWriteErr, next_pendWriteErr;
  logic        lastWasRts, next_lastWasRts;
  logic        reqValidQ, next_reqValid;
  logic [7:0]  vectorQ, next_vector;
  logic [3:0]  fsQ, next_fs;
  logic [3:0]  formatQ, next_format;
  logic        resetQ, next_reset;
  logic        resetOpcQ, next_resetOpc;
  logic        rollbackQ, next_rollback;
  logic        retOverQ, next_retOver;
  logic        nopStallQ, next_nopStall;
  logic [31:0] rdData, next_rdData;

  // ----------------------------------------------------------------
  // opword decode
  // ----------------------------------------------------------------
  logic [3:0] lineField;
  logic [5:0] opmodeField;
  logic [5:0] eaField;
  logic       eaIndexed;
  logic       indexFault;
  logic       lineAIllegal;
  logic       lineFIllegal;
  logic       stopIllegal;
  logic       haltIllegal;
  logic       anyIllegal;
  logic       isIllegalOp;
  logic       addrResetDis;
  logic       opcResetDis;

  // field split of the opword; extension words never reach the illegal check
  assign lineField   = opword[15:12];
  assign opmodeField = opword[11:6];
  assign eaField     = opword[5:0];
  assign eaIndexed   = (eaField[5:3] == `EA_MODE_INDEX) ||
                       (eaField == {`EA_MODE_SPECIAL, `EA_REG_PC_INDEX});
  // index format lives in extension word 1, only present when extCount is nonzero;
  // fixed 0x4e7x forms (stop, returns, control-register move) carry no effective address
  assign indexFault  = eaIndexed && (extCount != 2'h0) &&
                       (opword[15:4] != `OPW_FIXED_HI) &&
                       (!ext1[`EXT_SIZE_BIT] ||
                        (ext1[`EXT_SCALE_HI:`EXT_SCALE_LO] == `SCALE_EIGHT) ||
                        ext1[`EXT_FULL_BIT]);
  // move-3-quick is the only legal line-a form; write-debug forms in line f
  assign lineAIllegal = (lineField == `LINE_A) && (opmodeField[2:0] != `MOV3Q_OPMODE_LO);
  assign lineFIllegal = (lineField == `LINE_F) && (opmodeField[5:2] != `WDEBUG_HI);
  assign stopIllegal  = (opword == `OPW_STOP) &&
                        !modeCtrl[`BIT_STOP_EN] && !modeCtrl[`BIT_WAIT_EN];
  assign haltIllegal  = (opword == `OPW_HALT) && !modeCtrl[`BIT_BKGND_EN];
  assign isIllegalOp  = (opword == `OPW_ILLEGAL);
  assign anyIllegal   = lineAIllegal || lineFIllegal || stopIllegal || haltIllegal ||
                        isIllegalOp || (decodeIllegal && (lineField != `LINE_A) &&
                                        (lineField != `LINE_F));
  assign addrResetDis = coreConfig[`BIT_ADDR_RST_DIS];
  assign opcResetDis  = coreConfig[`BIT_OPC_RST_DIS];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // one request at a time; priority read error > fetch > illegal > address > write
  always_comb begin
    logic        raise;
    logic [7:0]  vec;
    logic [3:0]  fs;
    logic        isAddrClass;
    logic        forceExc;
    logic        rollback;
    logic        retOver;
    raise       = 1'b0;
    vec         = `VEC_ACCESS;
    fs          = `FS_NONE;
    isAddrClass = 1'b1;
    forceExc    = 1'b0;
    rollback    = 1'b0;
    retOver     = 1'b0;

    next_state        = state;
    next_coreConfig   = coreConfig;
    next_modeCtrl     = modeCtrl;
    next_pendFetchErr = pendFetchErr;
    next_pendWriteErr = pendWriteErr;
    next_lastWasRts   = lastWasRts;
    next_reqValid     = reqValidQ;
    next_vector       = vectorQ;
    next_fs           = fsQ;
    next_format       = formatQ;
    next_reset        = resetQ;
    next_resetOpc     = resetOpcQ;
    next_rollback     = rollbackQ;
    next_retOver      = retOverQ;
    next_nopStall     = nopStallQ;
    next_rdData       = 32'h0000_0000;

    // register writes steer reset selection and mode enables
    if (regWr && (regAddr == `OFS_CORE_CONFIG)) begin
      next_coreConfig = regWrData[1:0];
    end
    if (regWr && (regAddr == `OFS_MODE_CTRL)) begin
      next_modeCtrl = regWrData[2:0];
    end
    // read data stands the cycle after the strobe only
    if (regRd) begin
      unique case (regAddr)
        `OFS_CORE_CONFIG:  next_rdData = {30'h0, coreConfig};
        `OFS_MODE_CTRL:    next_rdData = {29'h0, modeCtrl};
        `OFS_FAULT_STATUS: next_rdData = {12'h0, pendWriteErr, pendFetchErr, reqValidQ, resetQ,
                                          formatQ, fsQ, vectorQ};
        default:           next_rdData = 32'h0000_0000;
      endcase
    end

    // prefetch fault is only held; a flush drops it, a new fault wins over the flush
    if (flowChange) begin
      next_pendFetchErr = 1'b0;
    end
    if (fetchErr) begin
      next_pendFetchErr = 1'b1;
    end

    // write errors are collected from the store buffer and reported later
    if (opWriteErr) begin
      next_pendWriteErr = 1'b1;
    end

    if (instValid) begin
      next_lastWasRts = (opword == `OPW_RTS);
    end

    unique case (state)
      fault_detect_pkg::ST_IDLE: begin
        if (opReadErr) begin
          // abort now; auto-address and partial multi-reg updates stay
          raise = 1'b1;
          vec   = `VEC_ACCESS;
          fs    = `FS_READ;
          rollback = 1'b0;
        end else if (instValid && pendFetchErr) begin
          raise    = 1'b1;
          vec      = `VEC_ACCESS;
          fs       = `FS_FETCH;
          rollback = 1'b1;
          // consumed only when reported; a read error that wins leaves it pending
          next_pendFetchErr = fetchErr;
        end else if (instValid && anyIllegal) begin
          raise       = 1'b1;
          isAddrClass = 1'b0;
          forceExc    = isIllegalOp;
          vec         = lineAIllegal ? `VEC_LINE_A :
                        lineFIllegal ? `VEC_LINE_F : `VEC_ILLEGAL;
          rollback    = 1'b1;
        end else if (instValid && indexFault) begin
          raise    = 1'b1;
          vec      = `VEC_ADDRESS;
          rollback = 1'b1;
        end else if (ctrlXfer && ctrlTargetBit0) begin
          raise   = 1'b1;
          vec     = `VEC_ADDRESS;
          retOver = lastWasRts;
        end else if (instValid && (opword == `OPW_NOP)) begin
          if (writesPending) begin
            next_state    = fault_detect_pkg::ST_NOPWAIT;
            next_nopStall = 1'b1;
          end else if (pendWriteErr || opWriteErr) begin
            raise = 1'b1;
            vec   = `VEC_ACCESS;
            fs    = `FS_WRITE;
          end
        end else if (instValid && pendWriteErr) begin
          // imprecise: taken at the next boundary, writer fully retired
          raise = 1'b1;
          vec   = `VEC_ACCESS;
          fs    = `FS_WRITE;
        end
        if (raise) begin
          next_state    = fault_detect_pkg::ST_REQ;
          next_reqValid = 1'b1;
          next_vector   = vec;
          next_fs       = fs;
          next_format   = {`FORMAT_BASE, sspLow};
          // class picks the disable bit; 0x4afc always forces the exception
          next_reset    = !forceExc && (isAddrClass ? !addrResetDis : !opcResetDis);
          next_resetOpc = !isAddrClass;
          next_rollback = rollback;
          next_retOver  = retOver;
          if (fs == `FS_WRITE) begin
            next_pendWriteErr = opWriteErr;
          end
        end
      end
      fault_detect_pkg::ST_NOPWAIT: begin
        // stall until the store buffer drains, then report what it left
        if (!writesPending) begin
          next_nopStall = 1'b0;
          if (pendWriteErr || opWriteErr) begin
            next_state        = fault_detect_pkg::ST_REQ;
            next_reqValid     = 1'b1;
            next_vector       = `VEC_ACCESS;
            next_fs           = `FS_WRITE;
            next_format       = {`FORMAT_BASE, sspLow};
            next_reset        = !addrResetDis;
            next_resetOpc     = 1'b0;
            next_rollback     = 1'b0;
            next_retOver      = 1'b0;
            next_pendWriteErr = 1'b0;
          end else begin
            next_state = fault_detect_pkg::ST_IDLE;
          end
        end
      end
      fault_detect_pkg::ST_REQ: begin
        // request held until taken; held fetch and write faults stay pending behind it, other events meanwhile are dropped
        if (reqAck) begin
          next_state    = fault_detect_pkg::ST_IDLE;
          next_reqValid = 1'b0;
          next_fs       = `FS_NONE;
          next_rollback = 1'b0;
          next_retOver  = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= fault_detect_pkg::ST_IDLE;
      coreConfig   <= `CORE_CONFIG_RST;
      modeCtrl     <= `MODE_CTRL_RST;
      pendFetchErr <= 1'b0;
      pendWriteErr <= 1'b0;
      lastWasRts   <= 1'b0;
      reqValidQ    <= 1'b0;
      vectorQ      <= 8'h00;
      fsQ          <= 4'h0;
      formatQ      <= 4'h0;
      resetQ       <= 1'b0;
      resetOpcQ    <= 1'b0;
      rollbackQ    <= 1'b0;
      retOverQ     <= 1'b0;
      nopStallQ    <= 1'b0;
      rdData       <= 32'h0000_0000;
    end else begin
      state        <= next_state;
      coreConfig   <= next_coreConfig;
      modeCtrl     <= next_modeCtrl;
      pendFetchErr <= next_pendFetchErr;
      pendWriteErr <= next_pendWriteErr;
      lastWasRts   <= next_lastWasRts;
      reqValidQ    <= next_reqValid;
      vectorQ      <= next_vector;
      fsQ          <= next_fs;
      formatQ      <= next_format;
      resetQ       <= next_reset;
      resetOpcQ    <= next_resetOpc;
      rollbackQ    <= next_rollback;
      retOverQ     <= next_retOver;
      nopStallQ    <= next_nopStall;
      rdData       <= next_rdData;
    end
  end

  // outputs straight from flops
  assign regRdData       = rdData;
  assign reqValid        = reqValidQ;
  assign reqVector       = vectorQ;
  assign reqFs           = fsQ;
  assign reqFormat       = formatQ;
  assign reqReset        = resetQ;
  assign reqResetOpcode  = resetOpcQ;
  assign reqRollback     = rollbackQ;
  assign reqRetOverwrite = retOverQ;
  assign nopStall        = nopStallQ;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  illegal_never_reset_a: assert property (
    (state == fault_detect_pkg::ST_IDLE) && instValid && !pendFetchErr && !opReadErr &&
    (opword == `OPW_ILLEGAL) |=> reqValid && !reqReset && (reqVector == `VEC_ILLEGAL))
    else $error("illegal opword produced a reset or wrong vector");

  read_fault_status_a: assert property (
    (state == fault_detect_pkg::ST_IDLE) && opReadErr |=> reqValid && (reqFs == `FS_READ) && !reqRollback)
    else $error("operand read error not reported at once");

  fetch_rollback_a: assert property (
    (state == fault_detect_pkg::ST_IDLE) && !opReadErr && instValid && pendFetchErr
    |=> reqValid && reqRollback && (reqFs == `FS_FETCH))
    else $error("fetch error not aborting with rollback");

  flush_drop_a: assert property (
    flowChange && !fetchErr |=> !pendFetchErr)
    else $error("flushed prefetch fault still held");

  addr_reset_sel_a: assert property (
    reqValid && !reqResetOpcode && $rose(reqValid) |-> (reqReset == !$past(coreConfig[`BIT_ADDR_RST_DIS])))
    else $error("address class reset choice wrong");

  opc_reset_sel_a: assert property (
    $rose(reqValid) && reqResetOpcode && ($past(opword) != `OPW_ILLEGAL) |-> (reqReset == !$past(opcResetDis)))
    else $error("opcode class reset choice wrong");

  odd_target_a: assert property (
    (state == fault_detect_pkg::ST_IDLE) && ctrlXfer && ctrlTargetBit0 && !opReadErr && !instValid
    |=> reqValid && (reqVector == `VEC_ADDRESS) && (reqFs == `FS_NONE))
    else $error("odd transfer target not flagged");

  format_range_a: assert property (
    reqValid |-> (reqFormat[3:2] == `FORMAT_BASE))
    else $error("frame format outside 4 to 7");

  nop_drain_a: assert property (
    nopStall && writesPending |=> nopStall)
    else $error("no-op released before writes drained");

  one_request_a: assert property (
    reqValid && !reqAck |=> reqValid && $stable(reqVector) && $stable(reqFs))
    else $error("request changed before acknowledge");

  stop_illegal_a: assert property (
    (state == fault_detect_pkg::ST_IDLE) && instValid && !pendFetchErr && !opReadErr &&
    (opword == `OPW_STOP) && (modeCtrl[1:0] == 2'h0) |=> reqValid && (reqVector == `VEC_ILLEGAL))
    else $error("stop without low-power modes not illegal");

  cover_line_a_c: cover property ($rose(reqValid) && (reqVector == `VEC_LINE_A));
  cover_write_nop_c: cover property (nopStall ##[1:20] $rose(reqValid) && (reqFs == `FS_WRITE));
  cover_rts_odd_c: cover property ($rose(reqRetOverwrite));
  cover_exc_path_c: cover property ($rose(reqValid) && !reqReset && (reqFs == `FS_FETCH));

endmodule // core_fault_detect_exception
